// ### design/lpmc_pkg.sv
// Purpose: constants and types for the low power mode controller
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: mode codes double as the MODE_O encoding
package lpmc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_IOCFG = 4'h8;

  // ==========================================================
  // field codes
  localparam logic [2:0] LP_STOP0 = 3'h0;
  localparam logic [2:0] LP_STOP1 = 3'h1;
  localparam logic [2:0] LP_STOP2 = 3'h2;
  localparam logic [2:0] LP_STANDBY = 3'h3;
  localparam logic [2:0] LP_SLEEP = 3'h4;

  localparam logic [1:0] CLK_MULTI = 2'h0;
  localparam logic [1:0] CLK_HSI = 2'h1;
  localparam logic [1:0] CLK_FAST_EXT = 2'h2;
  localparam logic [1:0] CLK_PLL = 2'h3;

  // multispeed oscillator range codes, higher code is faster
  localparam logic [3:0] MS_RANGE_2M = 4'h5;
  localparam logic [3:0] MS_RANGE_8M = 4'h7;
  localparam logic [3:0] MS_RANGE_48M = 4'hB;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    M_RUN = 3'b000,
    M_SLEEP = 3'b001,
    M_LPRUN = 3'b010,
    M_LPSLEEP = 3'b011,
    M_STOP0 = 3'b100,
    M_STOP1 = 3'b101,
    M_STOP2 = 3'b110,
    M_STANDBY = 3'b111
  } mode_e;

  typedef struct packed {
    logic [14:0] rsvd;
    logic hsi_on;
    logic fx_on;
    logic pll_on;
    logic [1:0] clk_sel;
    logic [3:0] ms_range;
    logic exit_hsi;
    logic wake_rise;
    logic ret_keep;
    logic rtc_keep;
    logic lprun_req;
    logic [2:0] lp_sel;
  } ctrl_s;

  typedef struct packed {
    logic [22:0] rsvd;
    logic w_rst;
    logic w_slow;
    logic w_rtc;
    logic w_pin;
    logic stop_flag;
    logic sb_flag;
    logic [2:0] mode;
  } stat_s;

  typedef struct packed {
    logic rst_pin;
    logic wdg;
    logic wk_pin;
    logic rtc;
    logic slow_fail;
  } sb_wake_s;

  typedef struct packed {
    logic cpu_clk;
    logic core_clk;
    logic pll;
    logic ms_osc;
    logic hsi;
    logic fx_osc;
    logic ls_osc;
    logic main_reg;
    logic lp_reg;
    logic low_leak;
    logic core_pwr;
    logic brownout;
    logic rtc;
    logic main_sram_pwr;
    logic ret_sram_pwr;
    logic [1:0] sysclk_sel;
    logic [3:0] ms_range;
  } pwr_s;

  // ==========================================================
  // reset values
  localparam ctrl_s CTRL_RST = '{ms_range: MS_RANGE_8M, default: '0};
  localparam logic [31:0] IOCFG_RST = 32'h0000_0000;

endpackage

// ### design/low_power_mode_controller.sv
// Purpose: power mode sequencer with clock, oscillator and regulator control
// Assumes: inputs synchronous to REF_CLK_I, one register port master
// Notes: PWR_O follows MODE_O by one clock
//
// Notes on behaviour
// R01: reset leaves device in Run mode
// R02: Sleep halts only processor, any event wakes
// R03: low-power run uses LP regulator, 2 MHz cap
// R04: low-power run may keep 16 MHz osc on
// R05: low-power sleep only from low-power run
// R06: low-power sleep wakes back to low-power run
// R07: Stop keeps SRAM and registers
// R08: Stop gates core clocks and fast oscillators
// R09: RTC active in Stop when configured
// R10: peripherals may enable 16 MHz osc in Stop
// R11: three Stop variants, variant 2 low leakage
// R12: Stop 0 keeps main regulator on
// R13: Stop exit clock multispeed or 16 MHz osc
// R14: Standby powers off core, PLL, fast oscillators
// R15: brownout monitor always active in Standby
// R16: Standby holds I/O in chosen pull state
// R17: Standby loses main SRAM and registers
// R18: second SRAM bank optionally kept in Standby
// R19: Standby exit: reset, watchdog, pin, RTC, osc fail
// R20: Standby exit runs multispeed osc, max 8 MHz
// R21: core writes mode then waits for interrupt
// R22: Stop wakeup resumes entry mode without reset
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module low_power_mode_controller (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic WFI_I,
  input wire logic WAKE_EVT_I,
  input wire logic PERIPH_HSI_REQ_I,
  input wire lpmc_pkg::sb_wake_s SB_WAKE_I,
  output lpmc_pkg::pwr_s PWR_O,
  output logic [2:0] MODE_O,
  output logic [31:0] IO_PULL_O,
  output logic IO_STBY_HOLD_O,
  output logic CORE_RST_O
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] clip(input logic [3:0] r, input logic [3:0] lim);
    clip = (r > lim) ? lim : r;
  endfunction

  function automatic logic is_stop(input lpmc_pkg::mode_e m);
    is_stop = (m == lpmc_pkg::M_STOP0) || (m == lpmc_pkg::M_STOP1) ||
              (m == lpmc_pkg::M_STOP2);
  endfunction

  // mode picked by a wait instruction, shared by Run and low-power run
  function automatic lpmc_pkg::mode_e entry_mode(input logic [2:0] sel, input logic from_lp);
    case (sel)
      lpmc_pkg::LP_STOP0: entry_mode = lpmc_pkg::M_STOP0;
      lpmc_pkg::LP_STOP1: entry_mode = lpmc_pkg::M_STOP1;
      lpmc_pkg::LP_STOP2: entry_mode = lpmc_pkg::M_STOP2;
      lpmc_pkg::LP_STANDBY: entry_mode = lpmc_pkg::M_STANDBY;
      // R05: low-power sleep only from low-power run
      default: entry_mode = from_lp ? lpmc_pkg::M_LPSLEEP : lpmc_pkg::M_SLEEP;
    endcase
  endfunction

  // ==========================================================
  // state
  lpmc_pkg::mode_e mode_r;
  lpmc_pkg::mode_e mode_nxt;
  lpmc_pkg::mode_e ret_r;
  lpmc_pkg::ctrl_s ctrl_r;
  lpmc_pkg::stat_s stat_r;
  lpmc_pkg::pwr_s pwr_nxt;
  lpmc_pkg::stat_s stat_rd;
  logic [31:0] iocfg_r;
  logic pin_q_r;
  logic pin_edge;
  logic sb_exit;
  logic stop_exit;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_iocfg;
  lpmc_pkg::stat_s wclr;

  assign wr_ctrl = WR_I && (ADDR_I == lpmc_pkg::OFS_CTRL);
  assign wr_stat = WR_I && (ADDR_I == lpmc_pkg::OFS_STAT);
  assign wr_iocfg = WR_I && (ADDR_I == lpmc_pkg::OFS_IOCFG);
  // write-one-clear mask laid out like the status word
  assign wclr = WDATA_I;

  // R19: wake pin edge polarity
  assign pin_edge = ctrl_r.wake_rise ? (SB_WAKE_I.wk_pin & ~pin_q_r) :
                    (~SB_WAKE_I.wk_pin & pin_q_r);

  // R19: standby exit sources
  assign sb_exit = (mode_r == lpmc_pkg::M_STANDBY) &&
                   (SB_WAKE_I.rst_pin | SB_WAKE_I.wdg | pin_edge |
                    SB_WAKE_I.rtc | SB_WAKE_I.slow_fail);
  assign stop_exit = is_stop(mode_r) && WAKE_EVT_I;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      pin_q_r <= 1'b0;
    end else begin
      pin_q_r <= SB_WAKE_I.wk_pin;
    end
  end

  // ==========================================================
  // mode sequencer
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      lpmc_pkg::M_RUN: begin
        if (WFI_I) begin
          // R21: entry only on wait instruction
          mode_nxt = entry_mode(ctrl_r.lp_sel, 1'b0);
        end else if (ctrl_r.lprun_req) begin
          mode_nxt = lpmc_pkg::M_LPRUN;
        end
      end
      lpmc_pkg::M_LPRUN: begin
        // wait wins over leaving low-power run in the same cycle
        if (WFI_I) begin
          mode_nxt = entry_mode(ctrl_r.lp_sel, 1'b1);
        end else if (!ctrl_r.lprun_req) begin
          mode_nxt = lpmc_pkg::M_RUN;
        end
      end
      lpmc_pkg::M_SLEEP: begin
        // R02: any event wakes
        if (WAKE_EVT_I) begin
          mode_nxt = lpmc_pkg::M_RUN;
        end
      end
      lpmc_pkg::M_LPSLEEP: begin
        // R06: back to low-power run
        if (WAKE_EVT_I) begin
          mode_nxt = lpmc_pkg::M_LPRUN;
        end
      end
      lpmc_pkg::M_STOP0, lpmc_pkg::M_STOP1, lpmc_pkg::M_STOP2: begin
        // R22: resume the entry mode
        if (WAKE_EVT_I) begin
          mode_nxt = ret_r;
        end
      end
      lpmc_pkg::M_STANDBY: begin
        if (sb_exit) begin
          mode_nxt = lpmc_pkg::M_RUN;
        end
      end
      default: mode_nxt = lpmc_pkg::M_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      // R01: reset to run
      mode_r <= lpmc_pkg::M_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // R22: remember where Stop was entered from
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      ret_r <= lpmc_pkg::M_RUN;
    end else if (is_stop(mode_nxt) && !is_stop(mode_r)) begin
      ret_r <= mode_r;
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      ctrl_r <= lpmc_pkg::CTRL_RST;
    end else if (sb_exit) begin
      // R17: core registers lost, standby bits kept
      ctrl_r <= lpmc_pkg::CTRL_RST;
      ctrl_r.rtc_keep <= ctrl_r.rtc_keep;
      ctrl_r.ret_keep <= ctrl_r.ret_keep;
      ctrl_r.wake_rise <= ctrl_r.wake_rise;
      // R20: multispeed range capped at 8 MHz
      ctrl_r.ms_range <= lpmc_pkg::MS_RANGE_8M;
    end else if (stop_exit) begin
      // R13: wake clock per software choice
      ctrl_r.clk_sel <= ctrl_r.exit_hsi ? lpmc_pkg::CLK_HSI : lpmc_pkg::CLK_MULTI;
      ctrl_r.ms_range <= clip(ctrl_r.ms_range, lpmc_pkg::MS_RANGE_48M);
      ctrl_r.pll_on <= 1'b0;
      ctrl_r.fx_on <= 1'b0;
      ctrl_r.hsi_on <= ctrl_r.exit_hsi;
    end else if (wr_ctrl) begin
      ctrl_r <= WDATA_I;
      ctrl_r.rsvd <= '0;
    end
  end

  // standby circuitry, survives standby
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      iocfg_r <= lpmc_pkg::IOCFG_RST;
    end else if (wr_iocfg) begin
      iocfg_r <= WDATA_I;
    end
  end

  // ==========================================================
  // status flags, set wins over write-one clear
  always_comb begin
    stat_rd = stat_r;
    stat_rd.mode = mode_r;
    stat_rd.rsvd = '0;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      stat_r <= '0;
    end else begin
      if (wr_stat) begin
        stat_r.sb_flag <= stat_r.sb_flag & ~wclr.sb_flag;
        stat_r.stop_flag <= stat_r.stop_flag & ~wclr.stop_flag;
        stat_r.w_pin <= stat_r.w_pin & ~wclr.w_pin;
        stat_r.w_rtc <= stat_r.w_rtc & ~wclr.w_rtc;
        stat_r.w_slow <= stat_r.w_slow & ~wclr.w_slow;
        stat_r.w_rst <= stat_r.w_rst & ~wclr.w_rst;
      end
      if (stop_exit) begin
        stat_r.stop_flag <= 1'b1;
      end
      if (sb_exit) begin
        stat_r.sb_flag <= 1'b1;
        stat_r.w_pin <= pin_edge;
        stat_r.w_rtc <= SB_WAKE_I.rtc;
        stat_r.w_slow <= SB_WAKE_I.slow_fail;
        stat_r.w_rst <= SB_WAKE_I.rst_pin | SB_WAKE_I.wdg;
      end
    end
  end

  // ==========================================================
  // register read port
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      case (ADDR_I)
        lpmc_pkg::OFS_CTRL: RDATA_O <= ctrl_r;
        lpmc_pkg::OFS_STAT: RDATA_O <= stat_rd;
        lpmc_pkg::OFS_IOCFG: RDATA_O <= iocfg_r;
        default: RDATA_O <= '0;
      endcase
    end else begin
      RDATA_O <= '0;
    end
  end

  // ==========================================================
  // power and clock controls
  always_comb begin
    pwr_nxt = '0;
    pwr_nxt.ls_osc = 1'b1;
    // R15: brownout monitor never off
    pwr_nxt.brownout = 1'b1;
    pwr_nxt.core_pwr = 1'b1;
    pwr_nxt.main_sram_pwr = 1'b1;
    pwr_nxt.ret_sram_pwr = 1'b1;
    pwr_nxt.rtc = 1'b1;
    pwr_nxt.sysclk_sel = ctrl_r.clk_sel;
    pwr_nxt.ms_range = ctrl_r.ms_range;
    case (mode_r)
      lpmc_pkg::M_RUN, lpmc_pkg::M_SLEEP: begin
        // R02: sleep gates only the cpu clock
        pwr_nxt.cpu_clk = (mode_r == lpmc_pkg::M_RUN);
        pwr_nxt.core_clk = 1'b1;
        pwr_nxt.main_reg = 1'b1;
        pwr_nxt.ms_osc = 1'b1;
        // a selected clock source is never switched off under the core
        pwr_nxt.hsi = ctrl_r.hsi_on | (ctrl_r.clk_sel == lpmc_pkg::CLK_HSI);
        pwr_nxt.fx_osc = ctrl_r.fx_on | (ctrl_r.clk_sel == lpmc_pkg::CLK_FAST_EXT);
        pwr_nxt.pll = ctrl_r.pll_on | (ctrl_r.clk_sel == lpmc_pkg::CLK_PLL);
      end
      lpmc_pkg::M_LPRUN, lpmc_pkg::M_LPSLEEP: begin
        // R05: low-power sleep stops only the cpu clock
        pwr_nxt.cpu_clk = (mode_r == lpmc_pkg::M_LPRUN);
        pwr_nxt.core_clk = 1'b1;
        // R03: lp regulator, multispeed range capped at 2 MHz
        pwr_nxt.lp_reg = 1'b1;
        pwr_nxt.ms_osc = 1'b1;
        pwr_nxt.sysclk_sel = lpmc_pkg::CLK_MULTI;
        pwr_nxt.ms_range = clip(ctrl_r.ms_range, lpmc_pkg::MS_RANGE_2M);
        // R04: kernel clock from 16 MHz osc
        pwr_nxt.hsi = ctrl_r.hsi_on;
      end
      lpmc_pkg::M_STOP0, lpmc_pkg::M_STOP1, lpmc_pkg::M_STOP2: begin
        // R08: core clocks and fast oscillators off
        // R07: sram and registers stay powered
        // R12: stop 0 keeps main regulator
        pwr_nxt.main_reg = (mode_r == lpmc_pkg::M_STOP0);
        pwr_nxt.lp_reg = (mode_r != lpmc_pkg::M_STOP0);
        // R11: stop 2 low leakage
        pwr_nxt.low_leak = (mode_r == lpmc_pkg::M_STOP2);
        // R10: peripheral wake detection clock
        pwr_nxt.hsi = PERIPH_HSI_REQ_I;
        // R09: rtc kept when configured
        pwr_nxt.rtc = ctrl_r.rtc_keep;
      end
      lpmc_pkg::M_STANDBY: begin
        // R14: core domain and main regulator off
        pwr_nxt.core_pwr = 1'b0;
        pwr_nxt.main_sram_pwr = 1'b0;
        // R18: optional retention via lp regulator
        pwr_nxt.ret_sram_pwr = ctrl_r.ret_keep;
        pwr_nxt.lp_reg = ctrl_r.ret_keep;
        pwr_nxt.rtc = ctrl_r.rtc_keep;
      end
      default: pwr_nxt.core_pwr = 1'b1;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      PWR_O <= '0;
    end else begin
      PWR_O <= pwr_nxt;
    end
  end

  // mode leads the power word by one clock
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      MODE_O <= lpmc_pkg::M_RUN;
    end else begin
      MODE_O <= mode_nxt;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      IO_PULL_O <= lpmc_pkg::IOCFG_RST;
    end else begin
      IO_PULL_O <= iocfg_r;
    end
  end

  // R16: pulls held during standby
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      IO_STBY_HOLD_O <= 1'b0;
    end else begin
      IO_STBY_HOLD_O <= (mode_nxt == lpmc_pkg::M_STANDBY);
    end
  end

  // R17: core restarts after standby
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      CORE_RST_O <= 1'b0;
    end else begin
      CORE_RST_O <= sb_exit;
    end
  end

endmodule

// ### tb/lpmc_properties.sv
// Purpose: concurrent checks on the power mode sequencer ports
// Assumes: PWR_O lags MODE_O by one clock
// Notes: power checks skip mode entry cycles and judge settled modes, transition checks judge the change cycle
`timescale 1ns/100ps
module lpmc_properties (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic WFI_I,
  input wire logic WAKE_EVT_I,
  input wire logic PERIPH_HSI_REQ_I,
  input wire lpmc_pkg::sb_wake_s SB_WAKE_I,
  input wire lpmc_pkg::pwr_s PWR_O,
  input wire logic [2:0] MODE_O,
  input wire logic [31:0] IO_PULL_O,
  input wire logic IO_STBY_HOLD_O,
  input wire logic CORE_RST_O
);
  // ==========================================================
  // mode checks
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // power lags mode, so a mode counts once it has held a clock
  sequence s_held(logic [2:0] m);
    MODE_O == m && $past(MODE_O) == m;
  endsequence
  sequence s_left(logic [2:0] m);
    $past(RST_N_I) && $past(MODE_O) == m && MODE_O != m;
  endsequence
  a_reset_run: assert property ($rose(RST_N_I) |-> MODE_O == 3'h0)
    else $error("mode not run after reset");
  a_sleep_cpu_only: assert property (s_held(3'h1) |-> !PWR_O.cpu_clk && PWR_O.core_clk)
    else $error("sleep gates wrong clocks");
  a_lprun_limits: assert property (s_held(3'h2) |-> PWR_O.lp_reg && !PWR_O.main_reg
    && PWR_O.ms_range <= lpmc_pkg::MS_RANGE_2M && PWR_O.sysclk_sel == lpmc_pkg::CLK_MULTI)
    else $error("low power run limits broken");
  a_lpsleep_entry: assert property (MODE_O == 3'h3 && $past(MODE_O) != 3'h3
    |-> $past(MODE_O) == 3'h2) else $error("low power sleep entered from wrong mode");
  a_lpsleep_exit: assert property (s_left(3'h3) |-> MODE_O == 3'h2)
    else $error("low power sleep woke to wrong mode");
  a_stop_clocks: assert property (MODE_O[2] && MODE_O != 3'h7 && $stable(MODE_O)
    |-> !PWR_O.core_clk && !PWR_O.pll && !PWR_O.ms_osc && !PWR_O.fx_osc && PWR_O.ls_osc
    && PWR_O.main_sram_pwr) else $error("stop clocks or retention wrong");
  a_stop0_main_reg: assert property (s_held(3'h4) |-> PWR_O.main_reg && !PWR_O.low_leak)
    else $error("stop 0 regulator wrong");
  a_stop2_leak: assert property (s_held(3'h6) |-> PWR_O.low_leak && !PWR_O.main_reg)
    else $error("stop 2 leakage state wrong");
  a_stop_resume: assert property ($past(RST_N_I) && $past(MODE_O[2]) && $past(MODE_O) != 3'h7
    && !MODE_O[2] |-> (MODE_O == 3'h0 || MODE_O == 3'h2) && !CORE_RST_O)
    else $error("stop exit went to wrong mode");
  a_standby_power: assert property (s_held(3'h7) |-> !PWR_O.core_pwr && PWR_O.brownout
    && !PWR_O.pll && !PWR_O.ms_osc && !PWR_O.hsi && !PWR_O.fx_osc && !PWR_O.main_sram_pwr)
    else $error("standby power state wrong");
  a_standby_io_hold: assert property (s_held(3'h7) |-> IO_STBY_HOLD_O)
    else $error("io hold missing in standby");
  a_standby_exit: assert property (CORE_RST_O |-> $past(MODE_O) == 3'h7 && MODE_O == 3'h0
    ##1 !CORE_RST_O) else $error("core reset pulse wrong");
  a_standby_clock: assert property (s_left(3'h7) |=> PWR_O.sysclk_sel == lpmc_pkg::CLK_MULTI
    && PWR_O.ms_range <= lpmc_pkg::MS_RANGE_8M) else $error("standby wake clock too fast");
endmodule

bind low_power_mode_controller lpmc_properties i_props (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .WFI_I(WFI_I), .WAKE_EVT_I(WAKE_EVT_I),
  .PERIPH_HSI_REQ_I(PERIPH_HSI_REQ_I), .SB_WAKE_I(SB_WAKE_I), .PWR_O(PWR_O),
  .MODE_O(MODE_O), .IO_PULL_O(IO_PULL_O), .IO_STBY_HOLD_O(IO_STBY_HOLD_O),
  .CORE_RST_O(CORE_RST_O)
);

// ### tb/core_model.sv
// Purpose: stand-in for the processor core and the wakeup sources
// Assumes: bench raises a request one clock ahead of the wire
// Notes: outputs are registered copies, so they move only after an edge
`timescale 1ns/100ps
module core_model (
  input wire logic clk_i,
  input wire logic [6:0] req_i,
  output logic wfi_o,
  output logic wake_o,
  output lpmc_pkg::sb_wake_s sb_o
);
  // ==========================================================
  // request drive
  initial {wfi_o, wake_o, sb_o} = 7'h00;
  always @(posedge clk_i) begin
    {sb_o, wake_o, wfi_o} <= req_i;
  end
endmodule

// ### tb/low_power_mode_controller_bench.sv
// Purpose: directed walk through every power mode and wake source
// Assumes: register port with read data one cycle after the strobe
// Notes: waits three clocks per change, enough for the pin edge lag
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module low_power_mode_controller_bench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic hsi_req = 1'h0;
  logic [6:0] req = 7'h00;
  logic [31:0] rdata, io_pull;
  logic wfi, wake, hold, core_rst;
  logic [2:0] mode;
  lpmc_pkg::sb_wake_s sb_wake;
  lpmc_pkg::pwr_s pwr;
  int bad_count = 0;
  int samples_checked = 0;
  int rst_pulses = 0;
  logic [31:0] cause [5] = '{32'h0000_0080, 32'h0000_0040, 32'h0000_0020, 32'h0000_0100,
    32'h0000_0100};
  core_model i_core (.clk_i(clk), .req_i(req), .wfi_o(wfi), .wake_o(wake), .sb_o(sb_wake));
  low_power_mode_controller i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .WFI_I(wfi), .WAKE_EVT_I(wake),
    .PERIPH_HSI_REQ_I(hsi_req), .SB_WAKE_I(sb_wake), .PWR_O(pwr), .MODE_O(mode),
    .IO_PULL_O(io_pull), .IO_STBY_HOLD_O(hold), .CORE_RST_O(core_rst));
  // ==========================================================
  // bus and event tasks
  initial begin
    forever #20 clk = ~clk;
  end
  // the core reset is a one-clock pulse, so count it where it is settled
  always @(negedge clk) begin
    if (core_rst === 1'b1) rst_pulses++;
  end
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    `CHK(rdata, exp)
  endtask
  task automatic poke(input logic [6:0] v);
    @(posedge clk);
    req <= v;
    @(posedge clk);
    req <= 7'h00;
    settle();
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    settle();
    `CHK({mode, pwr.cpu_clk, pwr.main_reg, pwr.ms_range}, 9'h037)
    rd_reg(lpmc_pkg::OFS_CTRL, 32'h0000_0700);
    rd_reg(4'hC, 32'h0000_0000);
    wr_reg(lpmc_pkg::OFS_CTRL, 32'h0000_0704);
    poke(7'h01);
    `CHK({mode, pwr.cpu_clk, pwr.core_clk}, 5'h05)
    poke(7'h02);
    `CHK(mode, 3'h0)
    wr_reg(lpmc_pkg::OFS_CTRL, 32'h0001_070C);
    settle();
    `CHK({mode, pwr.lp_reg, pwr.main_reg, pwr.ms_range}, 9'h0A5)
    `CHK(pwr.hsi, 1'h1)
    poke(7'h01);
    `CHK({mode, pwr.cpu_clk, pwr.core_clk}, 5'h0D)
    poke(7'h02);
    `CHK(mode, 3'h2)
    wr_reg(lpmc_pkg::OFS_CTRL, 32'h0000_0700);
    wr_reg(lpmc_pkg::OFS_IOCFG, 32'h0000_0009);
    for (int v = 0; v < 3; v++) begin
      @(posedge clk) hsi_req <= (v == 1);
      wr_reg(lpmc_pkg::OFS_CTRL, 32'h0000_4710 | 32'(v) | (v == 1 ? 32'h0000_0080 : 32'h0));
      poke(7'h01);
      `CHK(mode, 3'(4 + v))
      `CHK({pwr.core_clk, pwr.pll, pwr.ms_osc}, 3'h0)
      `CHK({pwr.fx_osc, pwr.ls_osc, pwr.main_sram_pwr}, 3'h3)
      `CHK({pwr.hsi, pwr.rtc}, {v == 1, 1'h1})
      `CHK({pwr.main_reg, pwr.low_leak}, {v == 0, v == 2})
      poke(7'h02);
      `CHK(mode, 3'h0)
      `CHK(pwr.pll, 1'h0)
      `CHK(pwr.sysclk_sel, (v == 1) ? lpmc_pkg::CLK_HSI : lpmc_pkg::CLK_MULTI)
      rd_reg(lpmc_pkg::OFS_STAT, 32'h0000_0010);
      wr_reg(lpmc_pkg::OFS_STAT, 32'h0000_0010);
    end
    rd_reg(lpmc_pkg::OFS_IOCFG, 32'h0000_0009);
    for (int i = 0; i < 5; i++) begin
      wr_reg(lpmc_pkg::OFS_CTRL, 32'h0000_0763);
      poke(7'h01);
      `CHK(mode, 3'h7)
      `CHK({pwr.core_pwr, pwr.pll, pwr.ms_osc}, 3'h0)
      `CHK({pwr.hsi, pwr.fx_osc, pwr.brownout}, 3'h1)
      `CHK({pwr.main_sram_pwr, pwr.ret_sram_pwr}, 2'h1)
      `CHK({hold, io_pull}, {1'h1, 32'h0000_0009})
      poke(7'(1 << (i + 2)));
      `CHK({mode, hold, pwr.sysclk_sel}, 6'h00)
      `CHK(pwr.ms_range <= lpmc_pkg::MS_RANGE_8M, 1'h1)
      rd_reg(lpmc_pkg::OFS_CTRL, 32'h0000_0760);
      `CHK(rst_pulses, i + 1)
      rd_reg(lpmc_pkg::OFS_STAT, 32'h0000_0008 | cause[i]);
      wr_reg(lpmc_pkg::OFS_STAT, 32'h0000_01F8);
    end
    tally_and_finish();
  end
endmodule
